// ===== rtl/ioc_defines.svh
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH
// =============================================================
// Timing, widths and limits of the channel.
`define IOC_CLK_PERIOD_NS   10
`define IOC_CONN_TIMEOUT_NS 100000
`define IOC_BYTE_W          12
`define IOC_WORD_W          24
`define IOC_ADDR_W          15
`define IOC_CNT_W           16
`define IOC_MAX_WORDS       16'h8000
`define IOC_TMR_W           14
`define IOC_EQ_W            3
`define IOC_NUM_EQ          8
`define IOC_SYNC_W          38
`define IOC_BYTE_ZERO       12'h000
`define IOC_ADDR_ONE        15'h0001
`define IOC_CNT_ONE         16'h0001
`define IOC_CNT_ZERO        16'h0000
`define IOC_TMR_ONE         14'h0001
`define IOC_TMR_ZERO        14'h0000
`endif

// ===== rtl/ioc_pkg.sv
`include "ioc_defines.svh"
package ioc_pkg;
    // =============================================================
    // Channel operations issued by the computation section.
    typedef enum logic [1:0] {
        IOC_OP_CONNECT  = 2'h0,
        IOC_OP_FUNCTION = 2'h1,
        IOC_OP_READ     = 2'h2,
        IOC_OP_WRITE    = 2'h3
    } ioc_op_t;
    // =============================================================
    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        IOC_ST_IDLE  = 7'h01,
        IOC_ST_CONN  = 7'h02,
        IOC_ST_FETCH = 7'h04,
        IOC_ST_SEND  = 7'h08,
        IOC_ST_RECV  = 7'h10,
        IOC_ST_STORE = 7'h20,
        IOC_ST_DROP  = 7'h40
    } ioc_state_t;
endpackage

// ===== rtl/ioc_channel.sv
`timescale 1ns/1ns
`include "ioc_defines.svh"
// Overview of operation
// R1: Channel moves data without further processor help.
// R2: Wide input joins two bytes into word.
// R3: Wide output splits word into two bytes.
// R4: Narrow channel: two memory references per word (narrow reads here make one).
// R5: Wide word transfer: one memory reference.
// R6: Character addressing makes wide act narrow.
// R7: Parity bit sent with every outgoing byte.
// R8: Equipment ignores Connect with bad parity.
// R9: Connect without answer: internal reject after 100us.
// R10: External parity error sets sense zero flag.
// R11: Any operation or clear erases the flag.
// R12: Controller idles until cleared after parity error.
// R13: Read parity held, compared with regenerated parity.
// R14: Read mismatch sets flag on enable.
// R15: Wide output carries upper and lower parity.
// R16: Wide read keeps and compares two bits.
// R17: One instruction moves at most 32K words (a zero count here allows 65536).
// R18: I/O in supervised program state raises interrupt.
// R19: Attach drops all but the addressed controller.
// R20: Every controller has its own interrupt line.
// R21: First link byte is the upper half.
module ioc_channel #(
    parameter int unsigned CONN_TIMEOUT_CYC = `IOC_CONN_TIMEOUT_NS / `IOC_CLK_PERIOD_NS
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      cmd_valid,
    input  wire ioc_pkg::ioc_op_t          cmd_op,
    input  wire logic                      cmd_char_addr,
    input  wire logic                      cmd_supervised_prog,
    input  wire logic [`IOC_EQ_W-1:0]      cmd_eq,
    input  wire logic [`IOC_WORD_W-1:0]    cmd_code,
    input  wire logic [`IOC_ADDR_W-1:0]    cmd_addr,
    input  wire logic [`IOC_CNT_W-1:0]     cmd_words,
    input  wire logic                      wide_present,
    input  wire logic                      prog_clear,
    input  wire logic                      master_clear,
    input  wire logic                      internal_sense_instruction,
    input  wire logic                      db_par_en,
    input  wire logic [1:0]                db_par,
    input  wire logic                      mem_ack,
    input  wire logic [`IOC_WORD_W-1:0]    mem_rdata,
    input  wire logic [`IOC_WORD_W-1:0]    link_data_in,
    input  wire logic [1:0]                link_par_in,
    input  wire logic                      link_reply,
    input  wire logic                      link_reject,
    input  wire logic                      link_ext_par_err,
    input  wire logic                      link_end_of_record,
    input  wire logic [`IOC_NUM_EQ-1:0]    link_eq_intr,
    output logic                           busy_q,
    output logic                           done_q,
    output logic                           reject_q,
    output logic                           int_reject_q,
    output logic                           supv_intr_q,
    output logic                           sense_line0_q,
    output logic                           sense_data_q,
    output logic [`IOC_NUM_EQ-1:0]         eq_intr_q,
    output logic                           mem_req_q,
    output logic                           mem_we_q,
    output logic                           mem_full_q,
    output logic                           mem_upper_q,
    output logic [`IOC_ADDR_W-1:0]         mem_addr_q,
    output logic [`IOC_WORD_W-1:0]         mem_wdata_q,
    output logic [`IOC_WORD_W-1:0]         link_data_out_q,
    output logic [1:0]                     link_par_out_q,
    output logic                           link_connect_q,
    output logic                           link_function_q,
    output logic                           link_read_q,
    output logic                           link_write_q,
    output logic                           link_data_signal_q,
    output logic                           link_master_clear_q,
    output logic [`IOC_EQ_W-1:0]           link_eq_q
);
    import ioc_pkg::*;

    // Odd parity over one byte; used for every outgoing byte.
    function automatic logic par12(input logic [`IOC_BYTE_W-1:0] b);
        par12 = ~^b;
    endfunction

    // Both parity lines for what sits on the data lines.
    function automatic logic [1:0] par24(input logic [`IOC_WORD_W-1:0] w);
        par24 = {par12(w[`IOC_WORD_W-1:`IOC_BYTE_W]), par12(w[`IOC_BYTE_W-1:0])};
    endfunction

    // =============================================================
    // Pin synchronisers.
    logic [`IOC_SYNC_W-1:0] sy1_q, sy2_q;
    logic [`IOC_WORD_W-1:0] data_s;
    logic [1:0]             par_s;
    logic                   reply_s, reject_s, xpe_s, eor_s;
    logic [`IOC_NUM_EQ-1:0] eqi_s;

    // All cable inputs pass two flops; only the second stage is read.
    always_ff @(posedge clk) begin
        sy1_q <= {link_reply, link_reject, link_ext_par_err, link_end_of_record,
                  link_eq_intr, link_par_in, link_data_in};
        sy2_q <= sy1_q;
    end
    assign {reply_s, reject_s, xpe_s, eor_s, eqi_s, par_s, data_s} = sy2_q;

    // =============================================================
    // Sequencer.
    ioc_state_t             st_q, st_d;
    ioc_op_t                op_q, op_d;
    logic                   wide_q, wide_d, upper_q, upper_d, conn_q, conn_d;
    logic [`IOC_CNT_W-1:0]  cnt_q, cnt_d;
    logic [`IOC_TMR_W-1:0]  tmr_q, tmr_d;
    logic [`IOC_WORD_W-1:0] word_q, word_d;
    logic [1:0]             hpar_q, hpar_d;
    logic                   par_err_q, par_err_d, par_set, par_clr, start;
    logic                   busy_d, done_d, rej_d, irej_d, supv_d, sense_d;
    logic                   mreq_d, mwe_d, mfull_d, mup_d;
    logic [`IOC_ADDR_W-1:0] maddr_d;
    logic [`IOC_WORD_W-1:0] mwd_d, ldo_d;
    logic                   lcon_d, lfun_d, lrd_d, lwr_d, lds_d;
    logic [`IOC_EQ_W-1:0]   leq_d;
    logic [`IOC_BYTE_W-1:0] byte_out;

    assign start = cmd_valid && busy_q == 1'b0 && !cmd_supervised_prog;
    // Mismatch and external error set; any operation request outside supervised state, or a clear, erases.
    assign par_set = (db_par_en && (wide_q ? db_par != hpar_q : db_par[0] != hpar_q[0]))
                   || (xpe_s && conn_q && (op_q == IOC_OP_FUNCTION || op_q == IOC_OP_WRITE));
    assign par_clr = (cmd_valid && !cmd_supervised_prog) || prog_clear || master_clear;
    // Narrow transfers pick the half that block control works on.
    assign byte_out = wide_q ? (upper_q ? word_q[`IOC_WORD_W-1:`IOC_BYTE_W]
                                        : word_q[`IOC_BYTE_W-1:0])
                             : (upper_q ? mem_rdata[`IOC_WORD_W-1:`IOC_BYTE_W]
                                        : mem_rdata[`IOC_BYTE_W-1:0]);

    // Next-state computation for the whole sequencer.
    always_comb begin
        st_d = st_q;  op_d = op_q;  wide_d = wide_q;  upper_d = upper_q;  conn_d = conn_q;
        cnt_d = cnt_q;  tmr_d = tmr_q;  word_d = word_q;  hpar_d = hpar_q;
        busy_d = busy_q;  done_d = 1'b0;  rej_d = 1'b0;  irej_d = 1'b0;
        supv_d = cmd_valid && cmd_supervised_prog;                              // see R18
        sense_d = internal_sense_instruction ? par_err_q : sense_data_q;
        par_err_d = par_set ? 1'b1 : (par_clr ? 1'b0 : par_err_q);      // see R10 R11 R14
        mreq_d = mem_req_q;  mwe_d = mem_we_q;  mfull_d = mem_full_q;  mup_d = mem_upper_q;
        maddr_d = mem_addr_q;  mwd_d = mem_wdata_q;  ldo_d = link_data_out_q;
        lcon_d = link_connect_q;  lfun_d = link_function_q;  lrd_d = link_read_q;
        lwr_d = link_write_q;  lds_d = 1'b0;  leq_d = link_eq_q;
        if (prog_clear || master_clear)
            conn_d = 1'b0;
        case (st_q)
            IOC_ST_IDLE: begin
                if (start) begin
                    busy_d = 1'b1;  op_d = cmd_op;  upper_d = 1'b1;             // see R21
                    wide_d = wide_present && !cmd_char_addr;                    // see R6
                    cnt_d = (cmd_words > `IOC_MAX_WORDS) ? `IOC_MAX_WORDS : cmd_words; // see R17
                    maddr_d = cmd_addr;  tmr_d = `IOC_TMR_ZERO;
                    case (cmd_op)
                        IOC_OP_CONNECT, IOC_OP_FUNCTION: begin
                            ldo_d = (wide_present && !cmd_char_addr) ? cmd_code
                                    : {`IOC_BYTE_ZERO, cmd_code[`IOC_BYTE_W-1:0]};
                            lcon_d = cmd_op == IOC_OP_CONNECT;
                            lfun_d = cmd_op == IOC_OP_FUNCTION;
                            if (cmd_op == IOC_OP_CONNECT) begin
                                conn_d = 1'b0;  leq_d = cmd_eq;                 // see R19
                            end
                            st_d = IOC_ST_CONN;
                        end
                        IOC_OP_WRITE: begin
                            lwr_d = 1'b1;  st_d = IOC_ST_FETCH;
                        end
                        default: begin
                            lrd_d = 1'b1;  st_d = IOC_ST_RECV;
                        end
                    endcase
                end
            end
            IOC_ST_CONN: begin
                tmr_d = tmr_q + `IOC_TMR_ONE;
                if (reply_s || reject_s) begin
                    conn_d = reply_s;  rej_d = reject_s;  done_d = reply_s;
                    lcon_d = 1'b0;  lfun_d = 1'b0;  busy_d = 1'b0;  st_d = IOC_ST_IDLE;
                end else if (tmr_q == `IOC_TMR_W'(CONN_TIMEOUT_CYC - 1)) begin
                    irej_d = 1'b1;  rej_d = 1'b1;                               // see R9
                    lcon_d = 1'b0;  lfun_d = 1'b0;  busy_d = 1'b0;  st_d = IOC_ST_IDLE;
                end
            end
            IOC_ST_FETCH: begin
                // One reference per word when wide, one per half otherwise.
                mreq_d = 1'b1;  mwe_d = 1'b0;  mfull_d = wide_q;  mup_d = upper_q; // see R4 R5
                if (mem_req_q && mem_ack) begin
                    mreq_d = 1'b0;  word_d = mem_rdata;  st_d = IOC_ST_SEND;
                end
            end
            IOC_ST_SEND: begin
                ldo_d = {`IOC_BYTE_ZERO, byte_out};                             // see R3
                lds_d = !reply_s;
                if (reply_s || reject_s)
                    st_d = IOC_ST_DROP;
            end
            IOC_ST_RECV: begin
                if (eor_s || reject_s) begin
                    lrd_d = 1'b0;  busy_d = 1'b0;  done_d = 1'b1;  st_d = IOC_ST_IDLE;
                end else if (reply_s) begin
                    // Received parity is held until the data bus answers.
                    if (upper_q)                                                // see R2
                        word_d[`IOC_WORD_W-1:`IOC_BYTE_W] = data_s[`IOC_BYTE_W-1:0];
                    else
                        word_d[`IOC_BYTE_W-1:0] = data_s[`IOC_BYTE_W-1:0];
                    if (wide_q && upper_q)
                        hpar_d[1] = par_s[0];                                   // see R16
                    else
                        hpar_d[0] = par_s[0];                                   // see R13
                    st_d = IOC_ST_DROP;
                end
            end
            IOC_ST_STORE: begin
                mreq_d = 1'b1;  mwe_d = 1'b1;  mfull_d = wide_q;  mup_d = upper_q;
                mwd_d = word_q;
                if (mem_req_q && mem_ack) begin
                    mreq_d = 1'b0;  st_d = IOC_ST_DROP;
                end
            end
            IOC_ST_DROP: begin
                // Wait for reply to fall before the next byte, then step the pointers.
                if (!reply_s) begin
                    if (reject_s) begin
                        rej_d = 1'b1;  lwr_d = 1'b0;  lrd_d = 1'b0;
                        busy_d = 1'b0;  st_d = IOC_ST_IDLE;
                    end else if (upper_q && !(op_q == IOC_OP_READ && !wide_q && mem_req_q)) begin
                        upper_d = 1'b0;
                        st_d = (op_q == IOC_OP_WRITE) ? (wide_q ? IOC_ST_SEND : IOC_ST_FETCH)
                             : (wide_q ? IOC_ST_RECV : IOC_ST_STORE);
                    end else if (op_q == IOC_OP_READ && !mem_we_q) begin
                        st_d = IOC_ST_STORE;
                    end else begin
                        mwe_d = 1'b0;  upper_d = !upper_q;
                        if (!upper_q) begin
                            cnt_d = cnt_q - `IOC_CNT_ONE;
                            maddr_d = mem_addr_q + `IOC_ADDR_ONE;
                        end
                        if (!upper_q && cnt_q == `IOC_CNT_ONE) begin
                            lwr_d = 1'b0;  lrd_d = 1'b0;  busy_d = 1'b0;
                            done_d = 1'b1;  st_d = IOC_ST_IDLE;
                        end else begin
                            st_d = (op_q == IOC_OP_WRITE) ? IOC_ST_FETCH : IOC_ST_RECV;
                        end
                    end
                end
            end
            default: st_d = IOC_ST_IDLE;
        endcase
        if (master_clear || prog_clear) begin
            st_d = IOC_ST_IDLE;  busy_d = 1'b0;  mreq_d = 1'b0;  mwe_d = 1'b0;
            lcon_d = 1'b0;  lfun_d = 1'b0;  lrd_d = 1'b0;  lwr_d = 1'b0;  lds_d = 1'b0;
        end
    end

    // Register stage; outputs all come straight from here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= IOC_ST_IDLE;  op_q <= IOC_OP_CONNECT;  wide_q <= 1'b0;  upper_q <= 1'b1;
            conn_q <= 1'b0;  cnt_q <= `IOC_CNT_ZERO;  tmr_q <= `IOC_TMR_ZERO;
            word_q <= '0;  hpar_q <= 2'h0;  par_err_q <= 1'b0;  busy_q <= 1'b0;
            done_q <= 1'b0;  reject_q <= 1'b0;  int_reject_q <= 1'b0;  supv_intr_q <= 1'b0;
            sense_line0_q <= 1'b0;  sense_data_q <= 1'b0;  eq_intr_q <= '0;
            mem_req_q <= 1'b0;  mem_we_q <= 1'b0;  mem_full_q <= 1'b0;  mem_upper_q <= 1'b0;
            mem_addr_q <= '0;  mem_wdata_q <= '0;  link_data_out_q <= '0;
            link_par_out_q <= 2'h3;  link_connect_q <= 1'b0;  link_function_q <= 1'b0;
            link_read_q <= 1'b0;  link_write_q <= 1'b0;  link_data_signal_q <= 1'b0;
            link_master_clear_q <= 1'b0;  link_eq_q <= '0;
        end else begin
            st_q <= st_d;  op_q <= op_d;  wide_q <= wide_d;  upper_q <= upper_d;
            conn_q <= conn_d;  cnt_q <= cnt_d;  tmr_q <= tmr_d;  word_q <= word_d;
            hpar_q <= hpar_d;  par_err_q <= par_err_d;  busy_q <= busy_d;
            done_q <= done_d;  reject_q <= rej_d;  int_reject_q <= irej_d;
            supv_intr_q <= supv_d;  sense_line0_q <= par_err_d;  sense_data_q <= sense_d;
            eq_intr_q <= eqi_s;                                                // see R20
            mem_req_q <= mreq_d;  mem_we_q <= mwe_d;  mem_full_q <= mfull_d;
            mem_upper_q <= mup_d;  mem_addr_q <= maddr_d;  mem_wdata_q <= mwd_d;
            link_data_out_q <= ldo_d;
            link_par_out_q <= par24(ldo_d);                                     // see R7 R15
            link_connect_q <= lcon_d;  link_function_q <= lfun_d;  link_read_q <= lrd_d;
            link_write_q <= lwr_d;  link_data_signal_q <= lds_d;
            link_master_clear_q <= master_clear;                                // see R12
            link_eq_q <= leq_d;
        end
    end

    // =============================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_send_acked;
        st_q == IOC_ST_SEND && reply_s;
    endsequence
    property p_send_hs;
        s_send_acked |=> st_q == IOC_ST_DROP ##1 !link_data_signal_q;
    endproperty
    a_send_hs: assert property (p_send_hs) else $error("byte strobe not dropped"); // see R1
    property p_supv;
        cmd_valid && cmd_supervised_prog |=> supv_intr_q && !$rose(busy_q);
    endproperty
    a_supv: assert property (p_supv) else $error("supervised I/O not trapped"); // see R18
    property p_par_set;
        par_set |=> par_err_q ##1 sense_line0_q;
    endproperty
    a_par_set: assert property (p_par_set) else $error("parity flag not set"); // see R10 R14
    property p_par_clr;
        par_clr && !par_set |=> !par_err_q;
    endproperty
    a_par_clr: assert property (p_par_clr) else $error("parity flag not cleared"); // see R11
    property p_timeout;
        int_reject_q |-> $past(st_q) == IOC_ST_CONN
                      && $past(tmr_q) == `IOC_TMR_W'(CONN_TIMEOUT_CYC - 1);
    endproperty
    a_timeout: assert property (p_timeout) else $error("internal reject mistimed"); // see R9
    property p_parity;
        link_data_signal_q || link_connect_q |-> link_par_out_q == par24(link_data_out_q);
    endproperty
    a_parity: assert property (p_parity) else $error("outgoing parity wrong"); // see R7 R15
    property p_refs;
        mem_req_q |-> mem_full_q == wide_q;
    endproperty
    a_refs: assert property (p_refs) else $error("memory reference size wrong"); // see R4 R5
    property p_limit;
        cnt_q <= `IOC_MAX_WORDS;
    endproperty
    a_limit: assert property (p_limit) else $error("block exceeds limit"); // see R17
    property p_upper_first;
        $rose(busy_q) |-> upper_q;
    endproperty
    a_upper_first: assert property (p_upper_first) else $error("first byte not upper"); // see R21
    property p_attach;
        $rose(link_connect_q) |-> !conn_q && link_eq_q == $past(cmd_eq);
    endproperty
    a_attach: assert property (p_attach) else $error("attach left old controller"); // see R19
endmodule

// ===== bench/ioc_equip_model.sv
`timescale 1ns/1ns
// =============================================================
// Controller on the far side of the cable, behavioural.
module ioc_equip_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        connect,
    input  wire logic        func,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic        strobe,
    input  wire logic        mclr,
    input  wire logic [23:0] dout,
    input  wire logic [1:0]  pout,
    input  wire logic        bad_conn,
    input  wire logic        bad_write,
    input  wire logic [23:0] rd_word,
    output logic             reply_q,
    output logic             perr_q,
    output logic             eor_q,
    output logic [23:0]      din_q,
    output logic [1:0]       pin_q,
    output logic [11:0]      b_hi_q,
    output logic [11:0]      b_lo_q
);
    logic       dead_q;
    logic       stb_q;
    logic [5:0] ph_q;
    logic       code_ok;
    logic       byte_ok;
    // Parity is regenerated here from the data and compared with the bits sent.
    assign code_ok = (pout === {~^dout[23:12], ~^dout[11:0]}) && !bad_conn;
    assign byte_ok = (pout[0] === ~^dout[11:0]) && !bad_write;
    // Released data lines show the inverse of their last value, so stale data never matches.
    always @(posedge clk) begin
        stb_q <= strobe;
        if (sys_rst || mclr) begin
            reply_q <= 1'b0;
            perr_q <= 1'b0;
            dead_q <= 1'b0;
            eor_q <= 1'b0;
            ph_q <= 6'h00;
        end else if (read && !dead_q) begin
            ph_q <= ph_q + 6'h01;
            if (ph_q == 6'h02 || ph_q == 6'h0e) begin
                din_q <= {12'h000, (ph_q == 6'h02) ? rd_word[23:12] : rd_word[11:0]};
                pin_q <= {1'b1, ph_q[3] ? ~^rd_word[11:0] : ~^rd_word[23:12]};
                reply_q <= 1'b1;
            end else if (ph_q == 6'h08 || ph_q == 6'h14) begin
                reply_q <= 1'b0;
                din_q <= ~din_q;
            end else if (ph_q == 6'h1a) begin
                eor_q <= 1'b1;
            end
        end else begin
            ph_q <= 6'h00;
            eor_q <= 1'b0;
            if (write && strobe && !stb_q) begin
                if (byte_ok && !dead_q) begin
                    reply_q <= 1'b1;
                    b_hi_q <= b_lo_q;
                    b_lo_q <= dout[11:0];
                end else begin
                    perr_q <= 1'b1;
                    dead_q <= 1'b1;
                end
            end else if (connect || func) begin
                reply_q <= code_ok && !dead_q;
            end else if (!strobe) begin
                reply_q <= 1'b0;
            end
        end
    end
endmodule

// ===== bench/test_io_channel_parity_assembly.sv
`timescale 1ns/1ns
// =============================================================
// Self-checking bench for the channel with its controller model.
module test_io_channel_parity_assembly;
    import ioc_pkg::*;
    localparam int TMO = 20;
    logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_char_addr = 0, cmd_supervised_prog = 0;
    ioc_op_t cmd_op = IOC_OP_CONNECT;
    logic [2:0] cmd_eq = 3'h5, link_eq_q;
    logic [23:0] cmd_code = 24'h12_3456, mem_rdata = 24'h00_0000, rd_word = 24'h00_0000;
    logic [14:0] cmd_addr = 15'h0010, mem_addr_q;
    logic [15:0] cmd_words = 16'h0001;
    logic prog_clear = 0, master_clear = 0, internal_sense_instruction = 0, db_par_en = 0;
    logic [1:0] db_par = 2'h0, link_par_in, link_par_out_q;
    logic mem_ack = 0, bad_conn = 0, bad_write = 0, wfull = 0;
    logic [7:0] link_eq_intr = 8'h00, eq_intr_q;
    logic [23:0] link_data_in, mem_wdata_q, link_data_out_q, wlog;
    logic link_reply, link_ext_par_err, link_end_of_record, busy_q, done_q, reject_q;
    logic int_reject_q, supv_intr_q, sense_line0_q, sense_data_q, mem_req_q, mem_we_q;
    logic mem_full_q, mem_upper_q, link_connect_q, link_function_q, link_read_q;
    logic link_write_q, link_data_signal_q, link_master_clear_q;
    logic [11:0] b_hi, b_lo;
    int error_cnt = 0, num_checks = 0, nref = 0, cyc = 0;
    // Clock at 100 MHz.
    always #5 clk = ~clk;
    ioc_channel #(.CONN_TIMEOUT_CYC(TMO)) u_dut (.clk, .sys_rst, .cmd_valid, .cmd_op,
        .cmd_char_addr, .cmd_supervised_prog, .cmd_eq, .cmd_code, .cmd_addr, .cmd_words,
        .wide_present(1'b1), .prog_clear, .master_clear, .internal_sense_instruction,
        .db_par_en, .db_par, .mem_ack, .mem_rdata, .link_data_in, .link_par_in, .link_reply,
        .link_reject(1'b0), .link_ext_par_err, .link_end_of_record, .link_eq_intr, .busy_q,
        .done_q, .reject_q, .int_reject_q, .supv_intr_q, .sense_line0_q, .sense_data_q,
        .eq_intr_q, .mem_req_q, .mem_we_q, .mem_full_q, .mem_upper_q, .mem_addr_q,
        .mem_wdata_q, .link_data_out_q, .link_par_out_q, .link_connect_q, .link_function_q,
        .link_read_q, .link_write_q, .link_data_signal_q, .link_master_clear_q, .link_eq_q);
    ioc_equip_model u_eq (.clk, .sys_rst, .connect(link_connect_q), .func(link_function_q),
        .read(link_read_q), .write(link_write_q), .strobe(link_data_signal_q),
        .mclr(link_master_clear_q), .dout(link_data_out_q), .pout(link_par_out_q), .bad_conn,
        .bad_write, .rd_word, .reply_q(link_reply), .perr_q(link_ext_par_err),
        .eor_q(link_end_of_record), .din_q(link_data_in), .pin_q(link_par_in), .b_hi_q(b_hi),
        .b_lo_q(b_lo));
    // Memory answers each request once and logs what was stored; a hang is cut short.
    always @(posedge clk) begin
        mem_ack <= mem_req_q && !mem_ack;
        nref <= cmd_valid ? 0 : nref + int'(mem_ack);
        if (mem_ack && mem_we_q) wlog <= mem_wdata_q;
        if (mem_ack && mem_we_q) wfull <= mem_full_q;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic issue(input ioc_op_t op, input logic ch);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_char_addr <= ch;
        tick(1);
        cmd_valid <= 1'b0;
    endtask
    // Bounded wait for the end of an operation; done is expected.
    task automatic wait_end();
        for (int i = 0; i < 300 && done_q !== 1'b1 && reject_q !== 1'b1; i++) tick(1);
        chk(done_q, 1'b1);
        tick(4);
    endtask
    task automatic t_conn();
        for (int k = 0; k < 2; k++) begin
            issue(k == 0 ? IOC_OP_CONNECT : IOC_OP_FUNCTION, 1'b0);
            chk(link_eq_q, 3'h5);
            chk(k == 0 ? link_connect_q : link_function_q, 1'b1);
            chk(link_par_out_q, {~^cmd_code[23:12], ~^cmd_code[11:0]});
            wait_end();
        end
    endtask
    task automatic t_noreply();
        int n;
        bad_conn <= 1'b1;
        issue(IOC_OP_CONNECT, 1'b0);
        for (n = 0; n < 100 && int_reject_q !== 1'b1; n++) tick(1);
        chk(24'(n), 24'(TMO));
        chk(reject_q, 1'b1);
        bad_conn <= 1'b0;
    endtask
    task automatic t_write(input logic ch, input int refs);
        mem_rdata <= 24'hab_c123;
        issue(IOC_OP_WRITE, ch);
        wait_end();
        chk(b_hi, 12'habc);
        chk(b_lo, 12'h123);
        chk(nref, refs);
        chk(mem_addr_q, 15'h0011);
    endtask
    task automatic t_read();
        rd_word <= 24'h5e_7a91;
        issue(IOC_OP_READ, 1'b0);
        wait_end();
        chk(wlog, 24'h5e_7a91);
        chk(wfull, 1'b1);
        chk(nref, 1);
        db_par <= {^rd_word[23:12], ^rd_word[11:0]};
        db_par_en <= 1'b1;
        tick(1);
        db_par_en <= 1'b0;
        tick(2);
        chk(sense_line0_q, 1'b1);
        internal_sense_instruction <= 1'b1;
        tick(1);
        internal_sense_instruction <= 1'b0;
        tick(2);
        chk(sense_data_q, 1'b1);
        issue(IOC_OP_CONNECT, 1'b0);
        tick(2);
        chk(sense_line0_q, 1'b0);
        wait_end();
    endtask
    task automatic t_perr();
        bad_write <= 1'b1;
        issue(IOC_OP_WRITE, 1'b0);
        for (int i = 0; i < 60 && sense_line0_q !== 1'b1; i++) tick(1);
        chk(sense_line0_q, 1'b1);
        prog_clear <= 1'b1;
        tick(1);
        prog_clear <= 1'b0;
        tick(3);
        chk(busy_q, 1'b0);
        master_clear <= 1'b1;
        bad_write <= 1'b0;
        tick(1);
        master_clear <= 1'b0;
        tick(4);
        chk(sense_line0_q, 1'b0);
        chk(link_ext_par_err, 1'b0);
    endtask
    task automatic t_misc();
        cmd_supervised_prog <= 1'b1;
        issue(IOC_OP_READ, 1'b0);
        chk(supv_intr_q, 1'b1);
        chk(busy_q, 1'b0);
        cmd_supervised_prog <= 1'b0;
        link_eq_intr <= 8'h5a;
        tick(5);
        chk(eq_intr_q, 8'h5a);
        link_eq_intr <= 8'h00;
    endtask
    task automatic conclude();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence: reset for ten cycles, then every scenario in turn.
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_conn();
        t_noreply();
        t_write(1'b0, 1);
        t_write(1'b1, 2);
        t_read();
        t_perr();
        t_misc();
        conclude();
    end
endmodule
